// ===== dv/skip_on_flag_instruction_logic_tb.sv
`timescale 1ns/1ns
module skip_on_flag_instruction_logic_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire logic hreadyout;
    wire logic hresp;
    wire logic [31:0] hrdata;
    logic exec_valid = 1'b0;
    logic [2:0] exec_op = 3'h0;
    wire logic skip_now;
    wire logic suppress;
    wire logic sys_reset_req;
    logic wake_set = 1'b0;
    logic [2:0] tmr_set = 3'h0;
    wire logic wake_flag;
    wire logic [2:0] tmr_flag;
    wire logic irq;
    logic rdy_q = 1'b0;
    logic [31:0] rd_q = 32'h0;
    int n_fail = 0;
    int checks_done = 0;

    always #5 hclk = ~hclk;

    skip_on_flag_instruction_logic u_skip_on_flag_instruction_logic (
        .hclk(hclk), .hresetn(hresetn), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .exec_valid(exec_valid), .exec_op(exec_op),
        .skip_now(skip_now), .suppress(suppress), .sys_reset_req(sys_reset_req),
        .wake_set(wake_set), .tmr_set(tmr_set), .wake_flag(wake_flag),
        .tmr_flag(tmr_flag), .irq(irq)
    );

    // Mid-cycle snapshot avoids racing the edge that ends the data phase
    always @(negedge hclk)
    begin
        rdy_q <= hreadyout;
        rd_q <= hrdata;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (n_fail == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge hclk); while (rdy_q !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (rdy_q !== 1'b1);
        q = rd_q;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, exp);
        check({31'h0, hresp}, 32'h0);
    endtask

    // One issued slot; skip and suppress are judged in the slot's own cycle
    task automatic slot(input logic [2:0] op, input logic exp_skip, input logic exp_sup);
        @(posedge hclk);
        exec_valid <= 1'b1;
        exec_op <= op;
        #1;
        check({31'h0, skip_now}, {31'h0, exp_skip});
        check({31'h0, suppress}, {31'h0, exp_sup});
        @(posedge hclk);
        exec_valid <= 1'b0;
        #1;
    endtask

    task automatic pulse(input logic w, input logic [2:0] t);
        @(posedge hclk);
        wake_set <= w;
        tmr_set <= t;
        @(posedge hclk);
        wake_set <= 1'b0;
        tmr_set <= 3'h0;
        #1;
    endtask

    task automatic test_regs();
        rd_chk(skip_pkg::ADDR_IRQ_CTL_ONE, 32'h0);
        rd_chk(skip_pkg::ADDR_INT_MASK, 32'h0);
        wr(skip_pkg::ADDR_IRQ_CTL_TWO, 32'h0000000F);
        rd_chk(skip_pkg::ADDR_IRQ_CTL_TWO, 32'h0000000F);
        wr(8'h18, 32'h0000000F);
        rd_chk(8'h18, 32'h0);
    endtask

    // Enable high must be a no-op; enable low clears and skips; the slot after is dead
    task automatic test_timers();
        logic [3:0] hi_one [3] = '{4'h4, 4'h8, 4'h0};
        logic [3:0] hi_two [3] = '{4'h0, 4'h0, 4'h1};
        logic [2:0] op;
        for (int t = 0; t < 3; t++)
        begin
            op = skip_pkg::TMR_OPS[3*t +: 3];
            wr(skip_pkg::ADDR_IRQ_CTL_ONE, {28'h0, hi_one[t]});
            wr(skip_pkg::ADDR_IRQ_CTL_TWO, {28'h0, hi_two[t]});
            pulse(1'b0, 3'h1 << t);
            slot(op, 1'b0, 1'b0);
            check({31'h0, tmr_flag[t]}, 32'h1);
            wr(skip_pkg::ADDR_IRQ_CTL_ONE, {28'h0, ~hi_one[t]});
            wr(skip_pkg::ADDR_IRQ_CTL_TWO, {28'h0, ~hi_two[t]});
            slot(op, 1'b1, 1'b0);
            check({31'h0, tmr_flag[t]}, 32'h0);
            pulse(1'b0, 3'h1 << t);
            slot(op, 1'b0, 1'b1);
            check({31'h0, tmr_flag[t]}, 32'h1);
            slot(op, 1'b1, 1'b0);
            slot(skip_pkg::OP_NOP, 1'b0, 1'b1);
            slot(op, 1'b0, 1'b0);
        end
    endtask

    task automatic test_wake();
        slot(skip_pkg::OP_SKIP_WAKE, 1'b0, 1'b0);
        pulse(1'b1, 3'h0);
        slot(skip_pkg::OP_SKIP_WAKE, 1'b1, 1'b0);
        check({31'h0, wake_flag}, 32'h1);
        slot(skip_pkg::OP_SKIP_WAKE, 1'b0, 1'b1);
        slot(skip_pkg::OP_SKIP_WAKE, 1'b1, 1'b0);
        rd_chk(skip_pkg::ADDR_EXEC_STATE, 32'h1);
        slot(skip_pkg::OP_NOP, 1'b0, 1'b1);
        wr(skip_pkg::ADDR_FLAGS, 32'h1);
        #1;
        check({31'h0, wake_flag}, 32'h0);
    endtask

    task automatic test_irq();
        rd_chk(skip_pkg::ADDR_INT_STATUS, 32'h0000000F);
        rd_chk(skip_pkg::ADDR_INT_STATUS, 32'h0);
        wr(skip_pkg::ADDR_INT_MASK, 32'h4);
        pulse(1'b0, 3'h4);
        @(posedge hclk);
        #1;
        check({31'h0, irq}, 32'h1);
        rd_chk(skip_pkg::ADDR_INT_STATUS, 32'h4);
        #1;
        check({31'h0, irq}, 32'h0);
        wr(skip_pkg::ADDR_INT_MASK, 32'h0);
        pulse(1'b1, 3'h0);
        @(posedge hclk);
        #1;
        check({31'h0, irq}, 32'h0);
    endtask

    task automatic test_sw_reset();
        wr(skip_pkg::ADDR_IRQ_CTL_ONE, 32'h0000000F);
        pulse(1'b0, 3'h7);
        slot(skip_pkg::OP_SW_RESET, 1'b0, 1'b0);
        check({31'h0, sys_reset_req}, 32'h1);
        @(posedge hclk);
        #1;
        check({31'h0, sys_reset_req}, 32'h0);
        check({29'h0, tmr_flag}, 32'h0);
        rd_chk(skip_pkg::ADDR_IRQ_CTL_ONE, 32'h0);
        rd_chk(skip_pkg::ADDR_INT_STATUS, 32'h0);
    endtask

    // Enable low must freeze flags and stall the bus
    task automatic test_ce();
        @(posedge hclk);
        ce <= 1'b0;
        tmr_set <= 3'h2;
        @(posedge hclk);
        #1;
        check({31'h0, hreadyout}, 32'h0);
        check({29'h0, tmr_flag}, 32'h0);
        @(posedge hclk);
        ce <= 1'b1;
        tmr_set <= 3'h0;
        #1;
        check({29'h0, tmr_flag}, 32'h0);
    endtask

    initial
    begin
        #200000;
        n_fail++;
        finish_test();
    end

    initial
    begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        test_regs();
        test_timers();
        test_wake();
        test_irq();
        test_sw_reset();
        test_ce();
        finish_test();
    end
endmodule

// ===== verilog/req_flag_cell.sv
`timescale 1ns/1ns
module req_flag_cell (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic soft_clr,
    // Flag control
    input wire logic set_evt,
    input wire logic test_go,
    input wire logic irq_en,
    // Results
    output logic flag,
    output logic skip
);

    logic flag_r;
    logic flag_nxt;
    logic test_live;

    // Enabled interrupt turns the test into a plain no-operation
    assign test_live = test_go & ~irq_en;
    assign skip = test_live & flag_r;
    assign flag = flag_r;

    // Set beats the test clear so a same-cycle request survives
    assign flag_nxt = soft_clr ? 1'b0 :
                      set_evt ? 1'b1 :
                      test_live ? 1'b0 : flag_r;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            flag_r <= 1'b0;
        else if (ce)
            flag_r <= flag_nxt;
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_TEST_CLEAR_SKIP: assert property ( // RULE2 RULE5 RULE8 RULE12
        flag_r && test_go && !irq_en && !set_evt && !soft_clr |-> skip ##1 !flag_r)
        else $error("Set flag not skipped and cleared by test");

    AST_TEST_NO_SKIP: assert property ( // RULE2 RULE5 RULE8
        test_go && !flag_r && !soft_clr |-> !skip ##1 (flag_r == $past(set_evt)))
        else $error("Clear flag caused a skip or changed wrongly");

    AST_TEST_NOP: assert property ( // RULE3 RULE6 RULE9
        test_go && irq_en && !soft_clr |-> !skip ##1 (flag_r == ($past(flag_r) | $past(set_evt))))
        else $error("Enabled test did not act as no-operation");

endmodule

// ===== verilog/skip_on_flag_instruction_logic.sv
`timescale 1ns/1ns
// Overview of operation
// RULE1: Wake-indicator test skips next instruction when flag set; flag stays unchanged.
// RULE2: Timer-1 test with enable low clears its flag, skipping if it was set.
// RULE3: Timer-1 test with enable high is a no-operation: no skip, no change.
// RULE4: Timer-1 enable is bit 2 of interrupt control register one.
// RULE5: Timer-2 test with enable low clears its flag, skipping if it was set.
// RULE6: Timer-2 test with enable high is a no-operation: no skip, no change.
// RULE7: Timer-2 enable is bit 3 of interrupt control register one.
// RULE8: Timer-3 test with enable low clears its flag, skipping if it was set.
// RULE9: Timer-3 test with enable high is a no-operation: no skip, no change.
// RULE10: Timer-3 enable is bit 0 of interrupt control register two.
// RULE11: Software reset instruction triggers a full system reset like any source.
// RULE12: Skipped instruction is suppressed; clear and skip happen in one cycle.
module skip_on_flag_instruction_logic #(
    parameter int CTL_W = skip_pkg::CTL_W
) (
    // Clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Execute port from the instruction pipeline
    input wire logic exec_valid,
    input wire logic [2:0] exec_op,
    output logic skip_now,
    output logic suppress,
    output logic sys_reset_req,
    // Flag set events
    input wire logic wake_set,
    input wire logic [2:0] tmr_set,
    // Flag state
    output logic wake_flag,
    output logic [2:0] tmr_flag,
    // Interrupt
    output logic irq
);

    localparam int NT = skip_pkg::NUM_TIMERS;

    logic [CTL_W-1:0] irq_ctl_one_r;
    logic [CTL_W-1:0] irq_ctl_one_nxt;
    logic [CTL_W-1:0] irq_ctl_two_r;
    logic [CTL_W-1:0] irq_ctl_two_nxt;
    logic [3:0] int_mask_r;
    logic [3:0] int_mask_nxt;
    logic [3:0] int_status_r;
    logic [3:0] int_status_nxt;
    logic [3:0] int_events;
    logic wake_flag_r;
    logic wake_flag_nxt;
    logic suppress_r;
    logic suppress_nxt;
    logic sreset_r;
    logic sreset_nxt;
    logic dwr_r;
    logic dwr_nxt;
    logic drd_r;
    logic drd_nxt;
    logic [7:0] daddr_r;
    logic [7:0] daddr_nxt;

    logic ahb_go;
    logic wr_go;
    logic rd_go;
    logic wr_ctl_one;
    logic wr_ctl_two;
    logic wr_flags;
    logic wr_mask;
    logic rd_status;
    logic [31:0] rd_data;

    logic exec_go;
    logic act;
    logic is_wake;
    logic is_software_system_reset;
    logic skip_wake;
    logic soft_clr;
    logic wake_clr;
    logic [NT-1:0] en_vec;
    logic [NT-1:0] test_go;
    logic [NT-1:0] tmr_skip;
    logic [NT-1:0] tmr_flag_w;

    // Bus side: zero wait states, stalls only while the clock enable is low
    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign ahb_go = hsel & htrans[1] & hready & ce;
    assign dwr_nxt = ahb_go & hwrite;
    assign drd_nxt = ahb_go & ~hwrite;
    assign daddr_nxt = ahb_go ? haddr[7:0] : daddr_r;
    assign wr_go = dwr_r & ce;
    assign rd_go = drd_r & ce;

    // Write and read-side-effect decode
    assign wr_ctl_one = wr_go & (daddr_r == skip_pkg::ADDR_IRQ_CTL_ONE);
    assign wr_ctl_two = wr_go & (daddr_r == skip_pkg::ADDR_IRQ_CTL_TWO);
    assign wr_flags = wr_go & (daddr_r == skip_pkg::ADDR_FLAGS);
    assign wr_mask = wr_go & (daddr_r == skip_pkg::ADDR_INT_MASK);
    assign rd_status = rd_go & (daddr_r == skip_pkg::ADDR_INT_STATUS);

    // Read mux; unmapped offsets read as zero
    assign rd_data =
        (daddr_r == skip_pkg::ADDR_IRQ_CTL_ONE) ? {{(32-CTL_W){1'b0}}, irq_ctl_one_r} :
        (daddr_r == skip_pkg::ADDR_IRQ_CTL_TWO) ? {{(32-CTL_W){1'b0}}, irq_ctl_two_r} :
        (daddr_r == skip_pkg::ADDR_FLAGS) ? {28'h0000000, tmr_flag_w, wake_flag_r} :
        (daddr_r == skip_pkg::ADDR_INT_STATUS) ? {28'h0000000, int_status_r} :
        (daddr_r == skip_pkg::ADDR_INT_MASK) ? {28'h0000000, int_mask_r} :
        (daddr_r == skip_pkg::ADDR_EXEC_STATE) ? {30'h0, sreset_r, suppress_r} :
        32'h00000000;
    assign hrdata = drd_r ? rd_data : 32'h00000000;

    // Enable bits picked from the control registers
    assign en_vec[0] = irq_ctl_one_r[skip_pkg::EN_ONE_BIT]; // RULE4
    assign en_vec[1] = irq_ctl_one_r[skip_pkg::EN_TWO_BIT]; // RULE7
    assign en_vec[2] = irq_ctl_two_r[skip_pkg::EN_THREE_BIT]; // RULE10

    // Instruction side; a suppressed slot runs no test or reset but still logs ST_SUPPRESS
    assign exec_go = exec_valid & ce;
    assign act = exec_go & ~suppress_r; // RULE12
    assign suppress = exec_valid & suppress_r; // RULE12
    assign is_wake = exec_op == skip_pkg::OP_SKIP_WAKE;
    assign is_software_system_reset = exec_op == skip_pkg::OP_SW_RESET;
    assign skip_wake = act & is_wake & wake_flag_r; // RULE1
    assign skip_now = skip_wake | (|tmr_skip); // RULE12

    genvar gi;
    generate
        for (gi = 0; gi < NT; gi = gi + 1)
        begin : g_tmr
            assign test_go[gi] = act & (exec_op == skip_pkg::TMR_OPS[3*gi +: 3]);
            req_flag_cell u_cell (
                .hclk(hclk),
                .hresetn(hresetn),
                .ce(ce),
                .soft_clr(soft_clr),
                .set_evt(tmr_set[gi]),
                .test_go(test_go[gi]), // RULE2 RULE5 RULE8
                .irq_en(en_vec[gi]), // RULE3 RULE6 RULE9
                .flag(tmr_flag_w[gi]),
                .skip(tmr_skip[gi])
            );
        end
    endgenerate

    // Skip marks the very next issued slot for suppression
    assign suppress_nxt = soft_clr ? 1'b0 : exec_go ? skip_now : suppress_r; // RULE12

    // Software reset fires one cycle later and clears this block like a hard reset
    assign sreset_nxt = act & is_software_system_reset; // RULE11
    assign soft_clr = sreset_r; // RULE11
    assign sys_reset_req = sreset_r;

    // Wake indicator: test never touches it; bus write of one clears, set wins
    assign wake_clr = wr_flags & hwdata[skip_pkg::FLAG_WAKE_BIT];
    assign wake_flag_nxt = soft_clr ? 1'b0 :
                           wake_set ? 1'b1 :
                           wake_clr ? 1'b0 : wake_flag_r; // RULE1

    assign irq_ctl_one_nxt = soft_clr ? skip_pkg::IRQ_CTL_RST :
                             wr_ctl_one ? hwdata[CTL_W-1:0] : irq_ctl_one_r;
    assign irq_ctl_two_nxt = soft_clr ? skip_pkg::IRQ_CTL_RST :
                             wr_ctl_two ? hwdata[CTL_W-1:0] : irq_ctl_two_r;
    assign int_mask_nxt = soft_clr ? skip_pkg::INT_MASK_RST :
                          wr_mask ? hwdata[3:0] : int_mask_r;

    // Sticky events; read clears, a new event in that cycle still lands
    assign int_events[skip_pkg::ST_SKIP] = exec_go & skip_now;
    assign int_events[skip_pkg::ST_SUPPRESS] = exec_go & suppress_r;
    assign int_events[skip_pkg::ST_TMR_REQ] = |tmr_set;
    assign int_events[skip_pkg::ST_WAKE] = wake_set;
    assign int_status_nxt = soft_clr ? skip_pkg::INT_STATUS_RST :
                            ((rd_status ? 4'h0 : int_status_r) | int_events);
    assign irq = |(int_status_r & int_mask_r);

    assign wake_flag = wake_flag_r;
    assign tmr_flag = tmr_flag_w;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dwr_r <= 1'b0;
            drd_r <= 1'b0;
            daddr_r <= 8'h00;
        end
        else if (ce)
        begin
            dwr_r <= dwr_nxt;
            drd_r <= drd_nxt;
            daddr_r <= daddr_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_ctl_one_r <= skip_pkg::IRQ_CTL_RST;
            irq_ctl_two_r <= skip_pkg::IRQ_CTL_RST;
            int_mask_r <= skip_pkg::INT_MASK_RST;
            int_status_r <= skip_pkg::INT_STATUS_RST;
        end
        else if (ce)
        begin
            irq_ctl_one_r <= irq_ctl_one_nxt;
            irq_ctl_two_r <= irq_ctl_two_nxt;
            int_mask_r <= int_mask_nxt;
            int_status_r <= int_status_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wake_flag_r <= 1'b0;
            suppress_r <= 1'b0;
            sreset_r <= 1'b0;
        end
        else if (ce)
        begin
            wake_flag_r <= wake_flag_nxt;
            suppress_r <= suppress_nxt;
            sreset_r <= sreset_nxt;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_WAKE_SKIP: assert property ( // RULE1
        exec_go && !suppress_r && is_wake |-> skip_now == wake_flag_r)
        else $error("Wake test skip does not follow the flag");

    AST_WAKE_HOLD: assert property ( // RULE1
        act && is_wake && !wake_set && !wake_clr && !soft_clr |=> $stable(wake_flag_r))
        else $error("Wake test changed the wake flag");

    AST_T1_ENABLE_BIT: assert property ( // RULE4
        act && exec_op == skip_pkg::OP_SKIP_T1 && irq_ctl_one_r[2] |-> !skip_now)
        else $error("Timer one test skipped with enable bit 2 set");

    AST_T2_ENABLE_BIT: assert property ( // RULE7
        act && exec_op == skip_pkg::OP_SKIP_T2 && !irq_ctl_one_r[3] && tmr_flag_w[1]
        |-> skip_now)
        else $error("Timer two test ignored enable bit 3");

    AST_T3_ENABLE_BIT: assert property ( // RULE10
        act && exec_op == skip_pkg::OP_SKIP_T3 && irq_ctl_two_r[0] && !soft_clr
        |-> !skip_now ##1 (tmr_flag_w[2] == ($past(tmr_flag_w[2]) | $past(tmr_set[2]))))
        else $error("Timer three test not a no-operation with enable bit 0 set");

    AST_SUPPRESS_NEXT: assert property ( // RULE12
        exec_go && !soft_clr |=> suppress_r == $past(skip_now))
        else $error("Skipped slot not marked or pending mark not cleared");

    // Pending mark must survive any gap between issued slots
    AST_SUPPRESS_HOLD: assert property ( // RULE12
        suppress_r && !exec_go && !soft_clr |=> suppress_r)
        else $error("Pending suppress lost before next slot");

    AST_SUPPRESS_QUIET: assert property ( // RULE12
        exec_valid && suppress_r |-> !skip_now && test_go == 3'b000 && !sreset_nxt)
        else $error("Suppressed slot had an effect");

    AST_SW_RESET: assert property ( // RULE11
        act && is_software_system_reset |=> sys_reset_req ##1 ((irq_ctl_one_r == skip_pkg::IRQ_CTL_RST &&
        irq_ctl_two_r == skip_pkg::IRQ_CTL_RST && !suppress_r && !wake_flag_r) ||
        !$past(ce)))
        else $error("Software reset did not reset the block");

    COV_WAKE_SKIP: cover property (act && is_wake && wake_flag_r);
    COV_T1_SKIP: cover property (test_go[0] && tmr_skip[0]);
    COV_SUPPRESSED: cover property (exec_go && suppress_r);
    COV_SW_RESET: cover property (sys_reset_req);

endmodule

// ===== verilog/skip_pkg.sv
package skip_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_IRQ_CTL_ONE = 8'h00;
    localparam logic [7:0] ADDR_IRQ_CTL_TWO = 8'h04;
    localparam logic [7:0] ADDR_FLAGS = 8'h08;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_INT_MASK = 8'h10;
    localparam logic [7:0] ADDR_EXEC_STATE = 8'h14;

    // Register widths and reset values
    localparam int CTL_W = 4;
    localparam logic [3:0] IRQ_CTL_RST = 4'h0;
    localparam logic [3:0] INT_MASK_RST = 4'h0;
    localparam logic [3:0] INT_STATUS_RST = 4'h0;

    // Enable bit positions inside the interrupt control registers
    localparam int EN_ONE_BIT = 2;
    localparam int EN_TWO_BIT = 3;
    localparam int EN_THREE_BIT = 0;

    // Flags register layout
    localparam int FLAG_WAKE_BIT = 0;
    localparam int FLAG_TMR_LSB = 1;

    // Interrupt status layout
    localparam int ST_SKIP = 0;
    localparam int ST_SUPPRESS = 1;
    localparam int ST_TMR_REQ = 2;
    localparam int ST_WAKE = 3;

    // Execute port operation codes
    localparam logic [2:0] OP_NOP = 3'h0;
    localparam logic [2:0] OP_SKIP_WAKE = 3'h1;
    localparam logic [2:0] OP_SKIP_T1 = 3'h2;
    localparam logic [2:0] OP_SKIP_T2 = 3'h3;
    localparam logic [2:0] OP_SKIP_T3 = 3'h4;
    localparam logic [2:0] OP_SW_RESET = 3'h5;

    localparam int NUM_TIMERS = 3;
    localparam logic [8:0] TMR_OPS = {OP_SKIP_T3, OP_SKIP_T2, OP_SKIP_T1};

endpackage
